// ==== uce_pkg.sv ====
`default_nettype none
package uce_pkg;
  localparam int NUM_EP = 16;
  localparam int EP_IDX_W = 4;
  localparam int ADDR_W = 8;
  localparam int IRQ_W = 3;
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] IST_OFS = 8'h04;
  localparam logic [7:0] IMK_OFS = 8'h08;
  localparam logic [7:0] PWR_OFS = 8'h0C;
  localparam logic [1:0] EP_PAGE = 2'h1;
  localparam int CFG_EYE_BIT = 7;
  localparam int CFG_MON_BIT = 6;
  localparam int CFG_SIDL_BIT = 4;
  localparam int CFG_ASUS_BIT = 0;
  localparam int EP_LOWSPEED_DIRECT_EN_BIT = 7;
  localparam int EP_RETRY_BIT = 6;
  localparam int EP_CONDIS_BIT = 4;
  localparam int EP_RX_BIT = 3;
  localparam int EP_TX_BIT = 2;
  localparam int EP_STALL_BIT = 1;
  localparam int EP_HSHK_BIT = 0;
  localparam int PWR_SUSP_BIT = 1;
  localparam int IRQ_STALL_BIT = 0;
  localparam int IRQ_SUSP_BIT = 1;
  localparam int IRQ_SETUP_BIT = 2;
  localparam logic [7:0] CFG_WMASK = 8'hD1;
  localparam logic [7:0] EP_WMASK = 8'hDF;
  localparam logic [7:0] PWR_WMASK = 8'h02;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } uce_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } uce_apb_rsp_type;

  typedef struct packed {
    logic [7:0]              cfg;
    logic [NUM_EP-1:0][7:0]  ep;
    logic [7:0]              pwr;
    logic [IRQ_W-1:0]        ist;
    logic [IRQ_W-1:0]        imk;
    logic                    susp_q;
    logic [31:0]             prdata;
    logic                    slverr;
  } uce_state_type;
endpackage : uce_pkg
`default_nettype wire

// ==== uce_ctrl.sv ====
`default_nettype none
module uce_ctrl (
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic                          clk_en,
  input  wire uce_pkg::uce_apb_req_type      apb_req,
  output uce_pkg::uce_apb_rsp_type           apb_rsp,
  input  wire logic                          host_mode,
  input  wire logic                          idle_mode,
  input  wire logic                          sleep_mode,
  input  wire logic                          xcvr_oe,
  input  wire logic [uce_pkg::NUM_EP-1:0]    stall_event,
  input  wire logic                          setup_token,
  input  wire logic [uce_pkg::EP_IDX_W-1:0]  token_ep,
  output logic                               eye_pattern_test_en,
  output logic                               drive_oe_monitor,
  output logic                               usb_run,
  output logic                               usb_suspended,
  output logic                               usb_clk48_en,
  output logic                               lowspeed_direct_en,
  output logic                               pre_token_required,
  output logic                               nak_retry_en,
  output logic [uce_pkg::NUM_EP-1:0]         ep_receive_en,
  output logic [uce_pkg::NUM_EP-1:0]         ep_transmit_en,
  output logic [uce_pkg::NUM_EP-1:0]         ep_setup_en,
  output logic [uce_pkg::NUM_EP-1:0]         ep_handshake_en,
  output logic                               setup_reject,
  output logic                               irq
);
  import uce_pkg::*;

  logic          rst_meta_r;
  logic          rst_n_r;
  uce_state_type st_r;
  uce_state_type st_nxt;
  logic          wr_en;
  logic          rd_setup;
  logic          ep_hit;
  logic [3:0]    ep_sel;
  logic [7:0]    addr;
  logic [7:0]    wbyte;
  logic [IRQ_W-1:0] irq_set;
  logic          soft_suspend;
  logic          auto_suspend_on_sleep;
  logic          stop_when_idle;

  // Synchronised reset release; assertion stays asynchronous.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // Merge a write byte into a register under its writable mask.
  function automatic logic [7:0] merge_wr(
    input logic [7:0] old_val,
    input logic [7:0] new_val,
    input logic [7:0] mask
  );
    merge_wr = (old_val & ~mask) | (new_val & mask);
  endfunction : merge_wr

  // Widen a register byte to a bus word; upper bits read as zero.
  function automatic logic [31:0] to_word(input logic [7:0] val);
    to_word = {24'h000000, val};
  endfunction : to_word

  assign addr     = apb_req.paddr;
  assign wbyte    = apb_req.pwdata[7:0];
  assign ep_hit   = (addr[7:6] == EP_PAGE) && (addr[1:0] == 2'h0);
  assign ep_sel   = addr[5:2];
  assign wr_en    = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_setup = apb_req.psel && !apb_req.penable;

  assign stop_when_idle        = st_r.cfg[CFG_SIDL_BIT];
  assign auto_suspend_on_sleep = st_r.cfg[CFG_ASUS_BIT];
  assign soft_suspend          = st_r.pwr[PWR_SUSP_BIT];

  // Transceiver and power outputs.
  assign eye_pattern_test_en = st_r.cfg[CFG_EYE_BIT];
  assign drive_oe_monitor = st_r.cfg[CFG_MON_BIT] && xcvr_oe;
  assign usb_suspended = soft_suspend ||
                         (auto_suspend_on_sleep && sleep_mode);
  assign usb_clk48_en = !usb_suspended;
  assign usb_run = !usb_suspended &&
                   !(stop_when_idle && idle_mode);

  // Host-only controls live in endpoint 0.
  assign lowspeed_direct_en = host_mode &&
                              st_r.ep[0][EP_LOWSPEED_DIRECT_EN_BIT];
  assign pre_token_required = host_mode &&
                              !st_r.ep[0][EP_LOWSPEED_DIRECT_EN_BIT];
  assign nak_retry_en = host_mode &&
                        !st_r.ep[0][EP_RETRY_BIT];

  always_comb begin
    for (int i = 0; i < NUM_EP; i++) begin
      ep_receive_en[i]   = st_r.ep[i][EP_RX_BIT];
      ep_transmit_en[i]  = st_r.ep[i][EP_TX_BIT];
      ep_handshake_en[i] = st_r.ep[i][EP_HSHK_BIT];
      // The disable bit only counts for bidirectional endpoints.
      ep_setup_en[i] = st_r.ep[i][EP_RX_BIT] &&
                       !(st_r.ep[i][EP_TX_BIT] &&
                         st_r.ep[i][EP_CONDIS_BIT]);
    end
  end

  assign setup_reject = setup_token && !ep_setup_en[token_ep];

  always_comb begin
    irq_set = IRQ_RESET;
    irq_set[IRQ_STALL_BIT] = |stall_event;
    irq_set[IRQ_SUSP_BIT]  = usb_suspended && !st_r.susp_q;
    irq_set[IRQ_SETUP_BIT] = setup_reject;
  end

  assign irq = |(st_r.ist & st_r.imk);

  assign apb_rsp = '{prdata:  st_r.prdata,
                     pready:  apb_req.psel && apb_req.penable,
                     pslverr: apb_req.psel && apb_req.penable &&
                              st_r.slverr};

  always_comb begin
    st_nxt = st_r;
    st_nxt.susp_q = usb_suspended;
    // Read data is captured in the setup phase so that prdata is a flop.
    if (rd_setup) begin
      st_nxt.prdata = 32'h00000000;
      st_nxt.slverr = 1'b0;
      if (ep_hit) begin
        st_nxt.prdata = to_word(st_r.ep[ep_sel]);
      end else begin
        unique case (addr)
          CFG_OFS: st_nxt.prdata = to_word(st_r.cfg);
          IST_OFS: st_nxt.prdata = {29'h00000000, st_r.ist};
          IMK_OFS: st_nxt.prdata = {29'h00000000, st_r.imk};
          PWR_OFS: st_nxt.prdata = to_word(st_r.pwr);
          default: st_nxt.slverr = 1'b1;
        endcase
      end
    end
    if (wr_en) begin
      if (ep_hit) begin
        st_nxt.ep[ep_sel] = merge_wr(st_r.ep[ep_sel], wbyte,
                                     EP_WMASK);
      end else begin
        unique case (addr)
          CFG_OFS: st_nxt.cfg = merge_wr(st_r.cfg, wbyte,
                                         CFG_WMASK);
          IST_OFS: st_nxt.ist = st_r.ist & ~wbyte[IRQ_W-1:0];
          IMK_OFS: st_nxt.imk = wbyte[IRQ_W-1:0];
          PWR_OFS: st_nxt.pwr = merge_wr(st_r.pwr, wbyte, PWR_WMASK);
          default: st_nxt.ist = st_nxt.ist;
        endcase
      end
    end
    // Hardware events win over a software clear in the same cycle.
    for (int i = 0; i < NUM_EP; i++) begin
      if (stall_event[i]) begin
        st_nxt.ep[i][EP_STALL_BIT] = 1'b1;
      end
    end
    st_nxt.ist = st_nxt.ist | irq_set;
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r.cfg    <= REG_RESET;
      st_r.ep     <= '0;
      st_r.pwr    <= REG_RESET;
      st_r.ist    <= IRQ_RESET;
      st_r.imk    <= IRQ_RESET;
      st_r.susp_q <= 1'b0;
      st_r.prdata <= 32'h00000000;
      st_r.slverr <= 1'b0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  sequence cfg_write_s;
    apb_req.psel && apb_req.penable && apb_req.pwrite &&
    (apb_req.paddr == CFG_OFS) && clk_en;
  endsequence

  sequence cfg_read_s;
    apb_req.psel && !apb_req.penable && !apb_req.pwrite &&
    (apb_req.paddr == CFG_OFS) && clk_en;
  endsequence

  sequence stall_seen_s;
    stall_event[0] && clk_en;
  endsequence

  reserved_zero_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    cfg_read_s |=> (apb_rsp.prdata[31:8] == 24'h000000))
    else $error("Config upper bits read nonzero.");

  cfg_holes_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (st_r.cfg & ~CFG_WMASK) == 8'h00)
    else $error("Unimplemented config bit set.");

  eye_follow_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    cfg_write_s |=> (eye_pattern_test_en ==
                     $past(apb_req.pwdata[CFG_EYE_BIT])))
    else $error("Eye test enable missed config write.");

  monitor_gate_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    !st_r.cfg[CFG_MON_BIT] |-> !drive_oe_monitor)
    else $error("Drive monitor active while disabled.");

  idle_stop_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (idle_mode && st_r.cfg[CFG_SIDL_BIT]) |-> !usb_run)
    else $error("Module ran in idle with stop set.");

  sleep_suspend_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (sleep_mode && st_r.cfg[CFG_ASUS_BIT]) |->
    (usb_suspended && !usb_clk48_en))
    else $error("No auto suspend on sleep.");

  stall_sticky_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    stall_seen_s |=> st_r.ep[0][EP_STALL_BIT] ##1
    (st_r.ep[0][EP_STALL_BIT] || $past(wr_en)))
    else $error("Stall flag not set by stall event.");

  condis_gate_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (ep_receive_en & ~ep_transmit_en & ~ep_setup_en) == '0)
    else $error("Setup disable acted on one-way endpoint.");

  setup_reject_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (setup_token && st_r.ep[token_ep][EP_CONDIS_BIT] &&
     st_r.ep[token_ep][EP_RX_BIT] && st_r.ep[token_ep][EP_TX_BIT])
    |-> setup_reject ##1 (st_r.ist[IRQ_SETUP_BIT] || !$past(clk_en)))
    else $error("Setup not rejected on bidirectional endpoint.");

  retry_host_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    !host_mode |-> (!nak_retry_en && !lowspeed_direct_en))
    else $error("Host control active outside host mode.");

  sequence ep_write_s;
    apb_req.psel && apb_req.penable && apb_req.pwrite && ep_hit &&
    clk_en;
  endsequence

  sequence ep_read_s;
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && ep_hit &&
    clk_en;
  endsequence

  ep_upper_zero_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    ep_read_s |=> (apb_rsp.prdata[31:8] == 24'h000000))
    else $error("Endpoint upper bits read nonzero.");

  ep_hole_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    ep_write_s |=> ((st_r.ep[$past(ep_sel)] & ~EP_WMASK) == 8'h00))
    else $error("Unimplemented endpoint bit stored a write.");

  rx_write_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    ep_write_s |=>
    (ep_receive_en[$past(ep_sel)] == $past(wbyte[EP_RX_BIT])))
    else $error("Receive enable missed endpoint write.");

  tx_write_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    ep_write_s |=>
    (ep_transmit_en[$past(ep_sel)] == $past(wbyte[EP_TX_BIT])))
    else $error("Transmit enable missed endpoint write.");

  hshk_write_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    ep_write_s |=>
    (ep_handshake_en[$past(ep_sel)] == $past(wbyte[EP_HSHK_BIT])))
    else $error("Handshake enable missed endpoint write.");

  mon_follow_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    st_r.cfg[CFG_MON_BIT] |-> (drive_oe_monitor == xcvr_oe))
    else $error("Drive monitor does not follow drive enable.");

  idle_run_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (!st_r.cfg[CFG_SIDL_BIT] && !usb_suspended) |-> usb_run)
    else $error("Module stopped although stop in idle is clear.");

  no_auto_susp_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (!st_r.cfg[CFG_ASUS_BIT] && !st_r.pwr[PWR_SUSP_BIT]) |->
    (!usb_suspended && usb_clk48_en))
    else $error("Module suspended without a suspend request.");

  soft_susp_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    st_r.pwr[PWR_SUSP_BIT] |-> (usb_suspended && !usb_clk48_en))
    else $error("Soft suspend did not stop the 48 MHz clock.");

  lowspeed_direct_en_host_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    host_mode |-> ((lowspeed_direct_en == st_r.ep[0][EP_LOWSPEED_DIRECT_EN_BIT]) &&
                   (pre_token_required == !st_r.ep[0][EP_LOWSPEED_DIRECT_EN_BIT])))
    else $error("Low-speed direct control wrong in host mode.");

  nak_host_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    host_mode |-> (nak_retry_en == !st_r.ep[0][EP_RETRY_BIT]))
    else $error("NAK retry control wrong in host mode.");

  setup_ok_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (setup_token && ep_setup_en[token_ep]) |-> !setup_reject)
    else $error("Setup rejected on an endpoint that allows it.");

  stall_irq_a: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    ((|stall_event) && clk_en) |=> st_r.ist[IRQ_STALL_BIT])
    else $error("Stall event did not set its status bit.");

  // Checked while reset holds, so it has no disable clause.
  reset_clear_a: assert property (
    @(posedge clk)
    !rst_n_r |-> ((st_r.cfg == REG_RESET) && (st_r.ep == '0) && !irq))
    else $error("Register not zero during reset.");
endmodule : uce_ctrl
`default_nettype wire

// ==== uce_bus_model.sv ====
`default_nettype none
module uce_bus_model (
  input  wire logic        clk,
  output logic [15:0]      stall_event,
  output logic             setup_token,
  output logic [3:0]       token_ep,
  output logic             xcvr_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] st_q;
  logic        su_q;
  logic [3:0]  ep_q;
  initial begin
    {stall_event, setup_token, token_ep, xcvr_oe} = '0;
    {st_q, su_q, ep_q} = '0;
  end
  // Between tokens the endpoint number keeps moving unless it is 1 or 9, so a design that looks
  // at it without the token strobe cannot pass by luck.
  always @(posedge clk) begin
    stall_event <= st_q;
    setup_token <= su_q;
    token_ep    <= su_q ? ep_q : ~token_ep + 4'h3;
    st_q        <= '0;
    su_q        <= 1'b0;
  end
  task stall(input int n);
    @(negedge clk);
    st_q[n] = 1'b1;
  endtask : stall
  task setup(input int n);
    @(negedge clk);
    su_q = 1'b1;
    ep_q = n[3:0];
  endtask : setup
  task drive(input logic on);
    @(posedge clk);
    xcvr_oe <= on;
  endtask : drive
endmodule : uce_bus_model
`default_nettype wire

// ==== usb_config_endpoint_control_tb.sv ====
`default_nettype none
module usb_config_endpoint_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import uce_pkg::*;
  logic            clk, reset_n, host_mode, idle_mode, sleep_mode;
  uce_apb_req_type req;
  uce_apb_rsp_type rsp;
  logic [15:0]     stall_event, ep_rx, ep_tx, ep_su, ep_hs;
  logic            setup_token, xcvr_oe, eye, mon, run, susp, c48;
  logic            lsd, pre, nak, rej, irq, e, x, clk_en;
  logic [3:0]      token_ep;
  logic [7:0]      f;
  logic [31:0]     q;
  int              n_errors = 0;
  int              samples_checked = 0;
  uce_ctrl i_dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .apb_req(req), .apb_rsp(rsp), .host_mode(host_mode),
    .idle_mode(idle_mode), .sleep_mode(sleep_mode), .xcvr_oe(xcvr_oe),
    .stall_event(stall_event), .setup_token(setup_token),
    .token_ep(token_ep), .eye_pattern_test_en(eye), .drive_oe_monitor(mon),
    .usb_run(run), .usb_suspended(susp), .usb_clk48_en(c48),
    .lowspeed_direct_en(lsd), .pre_token_required(pre),
    .nak_retry_en(nak), .ep_receive_en(ep_rx), .ep_transmit_en(ep_tx),
    .ep_setup_en(ep_su), .ep_handshake_en(ep_hs), .setup_reject(rej),
    .irq(irq));
  uce_bus_model i_bus (.clk(clk), .stall_event(stall_event),
    .setup_token(setup_token), .token_ep(token_ep), .xcvr_oe(xcvr_oe));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task print_verdict;
    $display("Checks %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task chk(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds the whole request until pready is seen high at a rising edge.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk({1'b0, q}, {1'b0, exp});
  endtask : rd
  task settle;
    repeat (3) @(negedge clk);
  endtask : settle
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
  initial begin
    req = '0;
    {reset_n, host_mode, idle_mode, sleep_mode} = '0;
    clk_en = 1'b1;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(CFG_OFS, 32'h0);
    for (int i = 0; i < 16; i++) rd(8'(8'h40 + 4 * i), 32'h0);
    apb(1'b1, CFG_OFS, 32'hFFFF_FFFF);
    rd(CFG_OFS, 32'h0000_00D1);
    settle();
    chk(eye, 1'b1);
    i_bus.drive(1'b1);
    settle();
    chk(mon, 1'b1);
    @(posedge clk) sleep_mode <= 1'b1;
    idle_mode <= 1'b1;
    settle();
    chk({run, susp, c48}, 3'b010);
    apb(1'b1, CFG_OFS, 32'h0);
    settle();
    chk({run, susp, c48, mon, eye}, 5'b10100);
    apb(1'b1, PWR_OFS, 32'hFFFF_FFFF);
    rd(PWR_OFS, 32'h2);
    settle();
    chk({susp, c48}, 2'b10);
    apb(1'b1, PWR_OFS, 32'h0);
    @(posedge clk) sleep_mode <= 1'b0;
    idle_mode <= 1'b0;
    // Endpoint i gets control pattern i, so all sixteen combinations show.
    for (int i = 0; i < 16; i++) begin
      f = {3'b111, i[3], i[2], i[1], 1'b0, i[0]};
      apb(1'b1, 8'(8'h40 + 4 * i), {24'hFFFFFF, f});
    end
    for (int i = 0; i < 16; i++) begin
      f = {3'b110, i[3], i[2], i[1], 1'b0, i[0]};
      x = i[2] & !(i[1] & i[3]);
      rd(8'(8'h40 + 4 * i), {24'h0, f});
      chk({ep_rx[i], ep_tx[i], ep_hs[i]}, {i[2], i[1], i[0]});
      chk(ep_su[i], x);
      i_bus.setup(i);
      @(negedge clk);
      chk(rej, !x);
    end
    chk({lsd, pre, nak}, 3'b000);
    @(posedge clk) host_mode <= 1'b1;
    settle();
    chk({lsd, pre, nak}, 3'b100);
    apb(1'b1, 8'h40, 32'h0);
    settle();
    chk({lsd, pre, nak}, 3'b011);
    apb(1'b1, IST_OFS, 32'h7);
    rd(IST_OFS, 32'h0);
    i_bus.stall(5);
    i_bus.stall(0);
    settle();
    chk(irq, 1'b0);
    rd(IST_OFS, 32'h1);
    rd(8'h54, 32'h0000_00CB);
    apb(1'b1, IMK_OFS, 32'h1);
    settle();
    chk(irq, 1'b1);
    apb(1'b1, IST_OFS, 32'h1);
    settle();
    chk(irq, 1'b0);
    apb(1'b1, IMK_OFS, 32'h4);
    i_bus.setup(15);
    settle();
    chk(irq, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    apb(1'b1, 8'h41, 32'hFF);
    chk(e, 1'b1);
    // A write while the clock enable is low must leave no trace.
    @(posedge clk) clk_en <= 1'b0;
    apb(1'b1, CFG_OFS, 32'hFF);
    clk_en <= 1'b1;
    rd(CFG_OFS, 32'h0);
    // A second reset in mid-run must clear what the tests left behind.
    @(posedge clk) reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    rd(8'h7C, 32'h0);
    rd(8'h54, 32'h0);
    print_verdict();
  end
endmodule : usb_config_endpoint_control_tb
`default_nettype wire
